// ### rtl/apc_clock_gen.sv
// Function
// - Infrared selector code 0 picks high-speed oscillator, code 1 peripheral PLL.
// - Four-bit M field divides by field plus one, 0 to 15.
// - Audio clock M field is five bits, divides by field plus one.
// - Serial audio clocks are source over M then N, running only when bit 31 set.
// - Serial audio selector: PLL0 1X, PLL0 4X, PLL1 half, PLL1 fifth.
// - Resampler clock gated by bit 31; selector PLL0 4X, peripheral, half, fifth.
// - Digital audio transmit clock gated, divided, uses serial audio selection.
// - Digital audio receive clock selector: peripheral, PLL1 half, PLL1 fifth.
// - Microphone selector: PLL0 1X, PLL1 half, PLL1 fifth; code 11 reserved.
// - Infrared reset bit 16 holds reset while 0, releases while 1.
// - Infrared bus clock bit 0 blocks while 0, passes while 1.
// - ADC bus register has active-low reset bit 16 and pass bit 0.
// - Thermal sensor bus register has active-low reset bit 16, pass bit 0.
// - Serial audio bus register: resets bits 16..18, pass bits 0..2, per port.
// - Digital audio bus register has active-low reset bit 16, pass bit 0.
// - Microphone clock gated and divided; bus register reset bit 16, pass bit 0.
// - All registers reset to zero: clocks off, buses masked, resets asserted.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module apc_clock_gen (
    // System.
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // AHB-Lite slave.
    input  wire logic                    hsel,
    input  wire logic [apc_pkg::AW-1:0]  haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    // Clock sources, sampled as synchronous levels.
    input  wire logic                    high_speed_oscillator,
    input  wire logic                    peripheral_pll_1x,
    input  wire logic                    audio_pll0_1x,
    input  wire logic                    audio_pll0_4x,
    input  wire logic                    audio_pll1_half,
    input  wire logic                    audio_pll1_fifth,
    // Generated clocks.
    output logic                         infrared_tx_clk,
    output logic [2:0]                   serial_audio_clk,
    output logic                         resampler_clk,
    output logic                         digital_audio_tx_clk,
    output logic                         digital_audio_rx_clk,
    output logic                         digital_mic_clk,
    // Module resets, active low.
    output logic                         infrared_tx_reset_n,
    output logic                         general_adc_reset_n,
    output logic                         thermal_sensor_reset_n,
    output logic [2:0]                   serial_audio_reset_n,
    output logic                         digital_audio_reset_n,
    output logic                         digital_mic_reset_n,
    // Module bus clock passes.
    output logic                         infrared_tx_bus_pass,
    output logic                         general_adc_bus_pass,
    output logic                         thermal_sensor_bus_pass,
    output logic [2:0]                   serial_audio_bus_pass,
    output logic                         digital_audio_bus_pass,
    output logic                         digital_mic_bus_pass
);

    logic [31:0]                regs      [apc_pkg::NREG];
    logic [31:0]                next_regs [apc_pkg::NREG];
    logic                       wr_pend;
    logic                       next_wr_pend;
    logic [3:0]                 wr_idx;
    logic [3:0]                 next_wr_idx;
    logic [31:0]                next_hrdata;
    logic                       addr_take;
    logic                       addr_hit;
    logic [3:0]                 addr_idx;
    logic [5:0]                 src;
    logic [apc_pkg::NCLK-1:0]   clk_vec;

    assign src = {audio_pll1_fifth, audio_pll1_half, audio_pll0_4x, audio_pll0_1x,
                  peripheral_pll_1x, high_speed_oscillator};

    // Address decode; unmapped offsets read zero and drop writes.
    always_comb
    begin
        addr_take = hsel & hready & (htrans == apc_pkg::HTRANS_NONSEQ |
                                     htrans == apc_pkg::HTRANS_SEQ);
        addr_hit  = 1'b0;
        addr_idx  = 4'h0;
        for (int i = 0; i < apc_pkg::NREG; i++)
        begin
            if (haddr[apc_pkg::AW-1:2] == apc_pkg::REG_OFFSET[i][apc_pkg::AW-1:2])
            begin
                addr_hit = 1'b1;
                addr_idx = 4'(i);
            end
        end
    end

    // Register writes land in the data phase, masked so reserved bits stay zero.
    always_comb
    begin
        for (int i = 0; i < apc_pkg::NREG; i++)
        begin
            next_regs[i] = regs[i];
            if (wr_pend && wr_idx == 4'(i))
            begin
                next_regs[i] = hwdata & apc_pkg::REG_MASK[i];
            end
        end
        next_wr_pend = addr_take & hwrite & addr_hit;
        next_wr_idx  = addr_idx;
        // Reads see the value after a write in the same cycle, so no stale data.
        next_hrdata  = hrdata;
        if (addr_take && !hwrite)
        begin
            next_hrdata = addr_hit ? next_regs[addr_idx] : 32'h0000_0000;
        end
    end

    // Register and bus state.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < apc_pkg::NREG; i++)
            begin
                regs[i] <= apc_pkg::REG_RESET;
            end
            wr_pend   <= 1'b0;
            wr_idx    <= 4'h0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < apc_pkg::NREG; i++)
            begin
                regs[i] <= next_regs[i];
            end
            wr_pend   <= next_wr_pend;
            wr_idx    <= next_wr_idx;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1; // Zero wait states, always OKAY.
            hresp     <= 1'b0;
        end
    end

    // One source mux and divider per generated clock.
    for (genvar g = 0; g < apc_pkg::NCLK; g++)
    begin : gen_clk
        localparam int RI = apc_pkg::CLK_REG[g];
        localparam int KD = apc_pkg::CLK_KIND[g];
        logic       lvl;
        logic       run;
        logic [2:0] pick;

        // A reserved code stops the divider as the gate does, so a clock caught
        // high by a selector change falls instead of freezing there.
        assign pick = apc_pkg::apc_src_pick(KD, regs[RI][apc_pkg::SEL_LSB +: 3]);
        assign run  = regs[RI][apc_pkg::GATE_BIT] & (pick != apc_pkg::S_NONE);

        apc_src_mux #(
            .KIND (apc_pkg::CLK_KIND[g])
        ) u_mux (
            .sel   (regs[RI][apc_pkg::SEL_LSB +: 3]),
            .src   (src),
            .level (lvl)
        );
        apc_clk_div u_div (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .src_level (lvl),
            .clk_on    (run),
            .fac_m     (regs[RI][apc_pkg::M_LSB +: 5]),
            .fac_n     (regs[RI][apc_pkg::N_LSB +: 2]),
            .div_clk   (clk_vec[g])
        );
    end

    // Generated clocks, each a divider flop.
    assign infrared_tx_clk      = clk_vec[0];
    assign serial_audio_clk     = clk_vec[3:1];
    assign resampler_clk        = clk_vec[4];
    assign digital_audio_tx_clk = clk_vec[5];
    assign digital_audio_rx_clk = clk_vec[6];
    assign digital_mic_clk      = clk_vec[7];

    // Resets and bus passes come straight from register bits.
    assign infrared_tx_reset_n     = regs[apc_pkg::R_IR_BGR][apc_pkg::RST_LSB];
    assign infrared_tx_bus_pass    = regs[apc_pkg::R_IR_BGR][apc_pkg::PASS_LSB];
    assign general_adc_reset_n     = regs[apc_pkg::R_ADC_BGR][apc_pkg::RST_LSB];
    assign general_adc_bus_pass    = regs[apc_pkg::R_ADC_BGR][apc_pkg::PASS_LSB];
    assign thermal_sensor_reset_n  = regs[apc_pkg::R_THS_BGR][apc_pkg::RST_LSB];
    assign thermal_sensor_bus_pass = regs[apc_pkg::R_THS_BGR][apc_pkg::PASS_LSB];
    assign serial_audio_reset_n    = regs[apc_pkg::R_SA_BGR][apc_pkg::RST_LSB +: 3];
    assign serial_audio_bus_pass   = regs[apc_pkg::R_SA_BGR][apc_pkg::PASS_LSB +: 3];
    assign digital_audio_reset_n   = regs[apc_pkg::R_DA_BGR][apc_pkg::RST_LSB];
    assign digital_audio_bus_pass  = regs[apc_pkg::R_DA_BGR][apc_pkg::PASS_LSB];
    assign digital_mic_reset_n     = regs[apc_pkg::R_DMIC_BGR][apc_pkg::RST_LSB];
    assign digital_mic_bus_pass    = regs[apc_pkg::R_DMIC_BGR][apc_pkg::PASS_LSB];

    // Checks on the bus and the outputs.
    sequence s_wr_addr(logic [apc_pkg::AW-1:0] a);
        hsel && hready && htrans == apc_pkg::HTRANS_NONSEQ && hwrite && haddr == a;
    endsequence
    sequence s_rd_addr;
        hsel && hready && htrans == apc_pkg::HTRANS_NONSEQ && !hwrite;
    endsequence

    chk_write_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_addr(apc_pkg::REG_OFFSET[apc_pkg::R_SA0_CLK]) |-> ##2
        regs[apc_pkg::R_SA0_CLK] == ($past(hwdata) & apc_pkg::MASK_CLK5))
        else $error("serial audio clock register lost a write");
    chk_sa_pass_write: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_addr(apc_pkg::REG_OFFSET[apc_pkg::R_SA_BGR]) |-> ##2
        serial_audio_bus_pass == $past(hwdata[2:0]) &&
        serial_audio_reset_n == $past(hwdata[18:16]))
        else $error("serial audio bus bits do not follow the write");

    chk_ir_bus_write: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_addr(apc_pkg::REG_OFFSET[apc_pkg::R_IR_BGR]) |-> ##2
        infrared_tx_reset_n == $past(hwdata[apc_pkg::RST_LSB]) &&
        infrared_tx_bus_pass == $past(hwdata[apc_pkg::PASS_LSB]))
        else $error("infrared bus bits do not follow the write");

    chk_mic_bus_write: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_addr(apc_pkg::REG_OFFSET[apc_pkg::R_DMIC_BGR]) |-> ##2
        digital_mic_reset_n == $past(hwdata[apc_pkg::RST_LSB]) &&
        digital_mic_bus_pass == $past(hwdata[apc_pkg::PASS_LSB]))
        else $error("microphone bus bits do not follow the write");

    // The gate must pull a running clock low on the very next edge.
    chk_sa_gate_fall: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(regs[apc_pkg::R_SA0_CLK][apc_pkg::GATE_BIT]) |=> !serial_audio_clk[0])
        else $error("serial audio clock still high after its gate fell");

    chk_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
        s_rd_addr and !addr_hit |=> hrdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");
    chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (regs[apc_pkg::R_IR_CLK] & ~apc_pkg::MASK_CLK4) == 32'h0000_0000 &&
        (regs[apc_pkg::R_SA_BGR] & ~apc_pkg::MASK_BGR3) == 32'h0000_0000)
        else $error("reserved bits hold a value");
    chk_sa_gate_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (!regs[apc_pkg::R_SA1_CLK][apc_pkg::GATE_BIT])[*3] |-> !serial_audio_clk[1])
        else $error("serial audio clock runs while off");
    chk_dmic_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
        (regs[apc_pkg::R_DMIC_CLK][apc_pkg::SEL_LSB +: 3] == 3'h3)[*3] |-> !digital_mic_clk)
        else $error("microphone clock runs on a reserved source");
    chk_darx_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
        (regs[apc_pkg::R_DARX_CLK][apc_pkg::SEL_LSB +: 3] == 3'h3)[*3] |-> !digital_audio_rx_clk)
        else $error("receive clock runs on a reserved source");
    chk_ir_div1: assert property (@(posedge hclk) disable iff (!hresetn)
        (regs[apc_pkg::R_IR_CLK] == 32'h8000_0000)[*3] |-> infrared_tx_clk == $past(high_speed_oscillator))
        else $error("undivided infrared clock does not follow the oscillator");
    chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp) else $error("slave stalled or answered with an error");

endmodule : apc_clock_gen
`default_nettype wire

// ### inc/apc_pkg.sv
`default_nettype none
package apc_pkg;

    // Register file geometry.
    localparam int NREG = 14;
    localparam int NCLK = 8;
    localparam int AW   = 12;

    // Register indices, in address order.
    localparam int R_IR_CLK   = 0;
    localparam int R_IR_BGR   = 1;
    localparam int R_ADC_BGR  = 2;
    localparam int R_THS_BGR  = 3;
    localparam int R_SA0_CLK  = 4;
    localparam int R_SA1_CLK  = 5;
    localparam int R_SA2_CLK  = 6;
    localparam int R_RS_CLK   = 7;
    localparam int R_SA_BGR   = 8;
    localparam int R_DATX_CLK = 9;
    localparam int R_DARX_CLK = 10;
    localparam int R_DA_BGR   = 11;
    localparam int R_DMIC_CLK = 12;
    localparam int R_DMIC_BGR = 13;

    // Byte offsets of the registers.
    localparam logic [AW-1:0] REG_OFFSET [NREG] = '{
        12'h9C0, 12'h9CC, 12'h9EC, 12'h9FC, 12'hA10, 12'hA14, 12'hA18,
        12'hA1C, 12'hA20, 12'hA24, 12'hA28, 12'hA2C, 12'hA40, 12'hA4C};

    // Writable bits per register; every other bit reads zero.
    localparam logic [31:0] MASK_CLK4 = 32'h8700_030F;
    localparam logic [31:0] MASK_CLK5 = 32'h8700_031F;
    localparam logic [31:0] MASK_BGR1 = 32'h0001_0001;
    localparam logic [31:0] MASK_BGR3 = 32'h0007_0007;
    localparam logic [31:0] REG_MASK [NREG] = '{
        MASK_CLK4, MASK_BGR1, MASK_BGR1, MASK_BGR1, MASK_CLK5, MASK_CLK5, MASK_CLK5,
        MASK_CLK5, MASK_BGR3, MASK_CLK5, MASK_CLK5, MASK_BGR1, MASK_CLK5, MASK_BGR1};
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // Field positions.
    localparam int GATE_BIT = 31;
    localparam int SEL_LSB  = 24;
    localparam int N_LSB    = 8;
    localparam int M_LSB    = 0;
    localparam int RST_LSB  = 16;
    localparam int PASS_LSB = 0;

    // Clock outputs and the register that drives each one.
    localparam int CLK_REG [NCLK] = '{R_IR_CLK, R_SA0_CLK, R_SA1_CLK, R_SA2_CLK,
                                      R_RS_CLK, R_DATX_CLK, R_DARX_CLK, R_DMIC_CLK};

    // Source selector families.
    localparam int K_IR   = 0;
    localparam int K_SA   = 1;
    localparam int K_RS   = 2;
    localparam int K_DARX = 3;
    localparam int K_DMIC = 4;
    localparam int CLK_KIND [NCLK] = '{K_IR, K_SA, K_SA, K_SA, K_RS, K_SA, K_DARX, K_DMIC};

    // Source lines and the code meaning no source.
    localparam logic [2:0] S_OSC   = 3'h0;
    localparam logic [2:0] S_PERI  = 3'h1;
    localparam logic [2:0] S_A0_1X = 3'h2;
    localparam logic [2:0] S_A0_4X = 3'h3;
    localparam logic [2:0] S_A1_H  = 3'h4;
    localparam logic [2:0] S_A1_F  = 3'h5;
    localparam logic [2:0] S_NONE  = 3'h7;
    localparam int NSRC = 6;

    // AHB transfer types.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    // Maps a selector code of a clock family to a source line.
    function automatic logic [2:0] apc_src_pick(input int kind, input logic [2:0] sel);
        logic [2:0] s;
        s = S_NONE;
        unique case (kind)
            K_IR:   s = (sel == 3'h0) ? S_OSC : (sel == 3'h1) ? S_PERI : S_NONE;
            K_SA:   s = (sel == 3'h0) ? S_A0_1X : (sel == 3'h1) ? S_A0_4X :
                        (sel == 3'h2) ? S_A1_H : (sel == 3'h3) ? S_A1_F : S_NONE;
            K_RS:   s = (sel == 3'h0) ? S_A0_4X : (sel == 3'h1) ? S_PERI :
                        (sel == 3'h2) ? S_A1_H : (sel == 3'h3) ? S_A1_F : S_NONE;
            K_DARX: s = (sel == 3'h0) ? S_PERI : (sel == 3'h1) ? S_A1_H :
                        (sel == 3'h2) ? S_A1_F : S_NONE;
            default: s = (sel == 3'h0) ? S_A0_1X : (sel == 3'h1) ? S_A1_H :
                         (sel == 3'h2) ? S_A1_F : S_NONE;
        endcase
        return s;
    endfunction : apc_src_pick

endpackage : apc_pkg
`default_nettype wire

// ### rtl/apc_src_mux.sv
`timescale 1ns/1ps
`default_nettype none
module apc_src_mux #(
    parameter int KIND = 0
) (
    // Selection.
    input  wire logic [2:0]  sel,
    input  wire logic [5:0]  src,
    // Chosen source level, low for reserved codes.
    output logic             level
);

    logic [2:0] pick;

    // Reserved codes give no source at all, so the divider sees no edges.
    always_comb
    begin
        pick  = apc_pkg::apc_src_pick(KIND, sel);
        level = (pick == apc_pkg::S_NONE) ? 1'b0 : src[pick];
    end

endmodule : apc_src_mux
`default_nettype wire

// ### rtl/apc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module apc_clk_div (
    // System.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Source and settings.
    input  wire logic        src_level,
    input  wire logic        clk_on,
    input  wire logic [4:0]  fac_m,
    input  wire logic [1:0]  fac_n,
    // Divided clock.
    output logic             div_clk
);

    logic       src_prev;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       next_out;
    logic [8:0] total;
    logic [8:0] half;
    logic       rise;

    // Ratio is (M+1) times 2^N; high for the first half of each period.
    always_comb
    begin
        total    = 9'(({4'h0, fac_m} + 9'h1) << fac_n);
        half     = 9'((total + 9'h1) >> 1);
        rise     = src_level & ~src_prev;
        next_cnt = cnt;
        next_out = div_clk;
        if (!clk_on)
        begin
            next_cnt = 8'h00;
            next_out = 1'b0;
        end
        else if (total == 9'h1)
        begin
            next_out = src_level;
        end
        else if (rise)
        begin
            // A shrunk ratio restarts the period instead of running out to 255.
            next_cnt = ({1'b0, cnt} >= total - 9'h1) ? 8'h00 : 8'(cnt + 8'h01);
            next_out = ({1'b0, next_cnt} < half);
        end
    end

    // Divider state.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            src_prev <= 1'b0;
            cnt      <= 8'h00;
            div_clk  <= 1'b0;
        end
        else
        begin
            src_prev <= src_level;
            cnt      <= next_cnt;
            div_clk  <= next_out;
        end
    end

    chk_div_off_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (!clk_on)[*2] |-> !div_clk) else $error("divided clock runs while gated off");

endmodule : apc_clk_div
`default_nettype wire

// ### dv/apc_clock_gen_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module apc_clock_gen_tb_top;

    // Ceiling on the run, well above the longest measured sequence.
    localparam int LIMIT = 60000;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [5:0]  src = 6'h00;
    logic        ir_clk, rs_clk, tx_clk, rx_clk, mic_clk;
    logic [2:0]  sa_clk, sa_rst_n, sa_pass;
    logic        ir_rst_n, adc_rst_n, thermal_sensor_reset_n_n, da_rst_n, mic_rst_n;
    logic        ir_pass, adc_pass, ths_pass, da_pass, mic_pass;
    logic [7:0]  clks;
    int          cnt [6] = '{default: 0};
    int          fails = 0;
    int          num_checks = 0;
    int          cycles = 0;

    // Clock outputs in the order of the design's clock table.
    assign clks = {mic_clk, rx_clk, tx_clk, rs_clk, sa_clk, ir_clk};

    apc_clock_gen u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .high_speed_oscillator(src[0]), .peripheral_pll_1x(src[1]), .audio_pll0_1x(src[2]),
        .audio_pll0_4x(src[3]), .audio_pll1_half(src[4]), .audio_pll1_fifth(src[5]),
        .infrared_tx_clk(ir_clk), .serial_audio_clk(sa_clk), .resampler_clk(rs_clk),
        .digital_audio_tx_clk(tx_clk), .digital_audio_rx_clk(rx_clk),
        .digital_mic_clk(mic_clk), .infrared_tx_reset_n(ir_rst_n),
        .general_adc_reset_n(adc_rst_n), .thermal_sensor_reset_n(thermal_sensor_reset_n_n),
        .serial_audio_reset_n(sa_rst_n), .digital_audio_reset_n(da_rst_n),
        .digital_mic_reset_n(mic_rst_n), .infrared_tx_bus_pass(ir_pass),
        .general_adc_bus_pass(adc_pass), .thermal_sensor_bus_pass(ths_pass),
        .serial_audio_bus_pass(sa_pass), .digital_audio_bus_pass(da_pass),
        .digital_mic_bus_pass(mic_pass)
    );

    // Free-running system clock, 100 ns period.
    always #50 hclk = ~hclk;

    // Sources with distinct periods of 4 to 14 cycles, slower than half of hclk so
    // that every edge is seen by the sampling dividers.
    always @(posedge hclk)
    begin
        for (int k = 0; k < 6; k++)
        begin
            if (cnt[k] == k + 1)
            begin
                cnt[k] <= 0;
                src[k] <= ~src[k];
            end
            else
                cnt[k] <= cnt[k] + 1;
        end
    end

    // A hang ends the run as a failure.
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            fails = fails + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Checks made: %0d, mismatches: %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Waits for an edge at which the slave shows ready; only the run's ceiling ends it.
    task automatic wait_ready();
        do
        begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask : wait_ready

    task automatic ahb_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= apc_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= 1'b1;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask : ahb_write

    task automatic ahb_read(input logic [11:0] a, output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= apc_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= 1'b0;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        wait_ready();
        d = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask : ahb_read

    // Period between the third and fourth rising edges, so a reconfigured divider
    // has run a whole period; zero when fewer than four edges arrive within the bound.
    task automatic measure(input int i, input int bound, output int per);
        int   e [4];
        int   k;
        logic prev;
        k = 0;
        per = 0;
        @(negedge hclk);
        prev = clks[i];
        for (int n = 0; n < bound && k < 4; n++)
        begin
            @(negedge hclk);
            if (clks[i] === 1'b1 && prev === 1'b0)
            begin
                e[k] = n;
                k = k + 1;
            end
            prev = clks[i];
        end
        if (k == 4)
            per = e[3] - e[2];
    endtask : measure

    function automatic logic [31:0] clk_word(input logic [2:0] sel, input logic [4:0] m,
                                             input logic [1:0] n);
        return {1'b1, 4'h0, sel, 14'h0, n, 3'h0, m};
    endfunction : clk_word

    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    // Reset values and read-back of every writable bit, reserved bits dropped.
    task automatic test_registers();
        logic [31:0] d;
        for (int i = 0; i < apc_pkg::NREG; i++)
        begin
            ahb_read(apc_pkg::REG_OFFSET[i], d);
            check("reset value", d, 32'h0000_0000);
        end
        check("resets", {24'h0, ir_rst_n, adc_rst_n, thermal_sensor_reset_n_n, sa_rst_n, da_rst_n, mic_rst_n},
              32'h0);
        check("passes", {24'h0, ir_pass, adc_pass, ths_pass, sa_pass, da_pass, mic_pass},
              32'h0);
        check("clocks", {24'h0, clks}, 32'h0);
        for (int i = 0; i < apc_pkg::NREG; i++)
        begin
            ahb_write(apc_pkg::REG_OFFSET[i], 32'hFFFF_FFFF);
            ahb_read(apc_pkg::REG_OFFSET[i], d);
            check("read back", d, apc_pkg::REG_MASK[i]);
        end
        check("resets on", {24'h0, ir_rst_n, adc_rst_n, thermal_sensor_reset_n_n, sa_rst_n, da_rst_n,
              mic_rst_n}, 32'h0000_00FF);
        check("passes on", {24'h0, ir_pass, adc_pass, ths_pass, sa_pass, da_pass, mic_pass},
              32'h0000_00FF);
        ahb_write(12'hA20, 32'h0005_0002);
        ahb_write(12'h9CC, 32'h0000_0001);
        // The last write lands on the edge the task returns at, so look once it settles.
        @(negedge hclk);
        check("port resets", {29'h0, sa_rst_n}, 32'h5);
        check("port passes", {29'h0, sa_pass}, 32'h2);
        check("ir bus", {30'h0, ir_rst_n, ir_pass}, 32'h1);
        ahb_write(12'hA50, 32'hFFFF_FFFF);
        ahb_read(12'hA50, d);
        check("unmapped", d, 32'h0000_0000);
    endtask : test_registers

    // Selector codes 0 to 3 of every clock, dividers at one, against the source periods.
    task automatic test_selectors();
        int exp_per [8][4] = '{'{4, 6, 0, 0}, '{8, 10, 12, 14}, '{8, 10, 12, 14},
                               '{8, 10, 12, 14}, '{10, 6, 12, 14}, '{8, 10, 12, 14},
                               '{6, 12, 14, 0}, '{8, 12, 14, 0}};
        int per;
        for (int i = 0; i < apc_pkg::NCLK; i++)
            for (int c = 0; c < 4; c++)
            begin
                ahb_write(apc_pkg::REG_OFFSET[apc_pkg::CLK_REG[i]], clk_word(3'(c), 5'h0, 2'h0));
                measure(i, 200, per);
                check("source period", 32'(per), 32'(exp_per[i][c]));
            end
    endtask : test_selectors

    // Divider ratios at field boundaries, then the gate stopping the clock.
    task automatic test_dividers();
        int          idx [6] = '{1, 1, 1, 4, 0, 7};
        logic [2:0]  sel [6] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h2};
        logic [4:0]  m [6]   = '{5'h02, 5'h1F, 5'h00, 5'h04, 5'h1F, 5'h01};
        logic [1:0]  n [6]   = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h0, 2'h1};
        int          exp_per [6] = '{48, 256, 64, 120, 64, 56};
        int          per;
        for (int t = 0; t < 6; t++)
        begin
            ahb_write(apc_pkg::REG_OFFSET[apc_pkg::CLK_REG[idx[t]]], clk_word(sel[t], m[t], n[t]));
            measure(idx[t], 1500, per);
            check("divided period", 32'(per), 32'(exp_per[t]));
        end
        ahb_write(12'hA10, 32'h0000_0102);
        measure(1, 1500, per);
        check("gated clock", 32'(per), 32'h0);
        check("gated level", {31'h0, sa_clk[0]}, 32'h0);
    endtask : test_dividers

    // Main sequence, with a second reset in mid-run.
    initial
    begin
        logic [31:0] d;
        do_reset();
        test_registers();
        test_selectors();
        test_dividers();
        do_reset();
        ahb_read(12'hA24, d);
        check("second reset", d, 32'h0000_0000);
        check("clocks again", {24'h0, clks}, 32'h0);
        check("passes again", {24'h0, ir_pass, adc_pass, ths_pass, sa_pass, da_pass, mic_pass},
              32'h0);
        stop_test();
    end

endmodule : apc_clock_gen_tb_top
`default_nettype wire
